// ==== hw/cad_alu.sv ====
// Purpose: instruction-level alu datapath of an 8-bit cpu core
// Assumes: inputs synchronous to CLK_SYS; memory data valid on MEM_RDATA
//          in the last instruction clock
// Notes:   registers X A C B E D L H live here; loads only when idle
// Function
// - word move/exchange only with BC, DE, HL, 4 clocks
// - one instruction clock per cpu clock period
// - clock counts as for internal rom execution
// - fast column for fast ram or no access
// - slow column for any other data area
// - saddr immediate add writes memory, 6/8 clocks
// - pointer plus offset add, 8/9 clocks
// - add with carry includes incoming carry
// - subtract with borrow also subtracts carry
// - and updates zero flag only
// - or via pointer pair takes 4/5 clocks
// - xor including register destination form
// - word immediate add, no carry in, sets carry, 6 clocks
// - divide pair by C, 25 clocks
// - pair decrement keeps flags, 4 clocks
// - rotate left: bit 7 to bit 0, carry
`timescale 1ns/10ps
module cad_alu
    import cad_pkg::*;
(
    input  wire logic        CLK_SYS,
    input  wire logic        RSTN,
    input  wire logic        START,
    input  wire logic [3:0]  OPCODE,
    input  wire logic [3:0]  FORM,
    input  wire logic [2:0]  REG_SEL,
    input  wire logic [1:0]  PAIR_SEL,
    input  wire logic [7:0]  IMM_BYTE,
    input  wire logic [15:0] IMM_WORD,
    input  wire logic [15:0] ADDR_IN,
    input  wire logic        SLOW_AREA,
    input  wire logic [7:0]  MEM_RDATA,
    input  wire logic        LOAD_EN,
    input  wire logic [2:0]  LOAD_IDX,
    input  wire logic [7:0]  LOAD_DATA,
    input  wire logic        FLAG_LOAD,
    input  wire logic [2:0]  FLAGS_IN,
    output logic             BUSY,
    output logic             DONE,
    output logic             ILLEGAL,
    output logic [1:0]       INSTR_LEN,
    output logic [15:0]      MEM_ADDR,
    output logic             MEM_RE,
    output logic             MEM_WE,
    output logic [7:0]       MEM_WDATA,
    output logic [15:0]      ACC_PAIR,
    output logic [63:0]      REGS_OUT,
    output logic             FLAG_Z,
    output logic             FLAG_AC,
    output logic             FLAG_CY
);
    import cad_pkg::*;

    cad_state_t  state_reg, state_next;
    logic [4:0]  cnt_reg, cnt_next;
    logic [63:0] regs_reg, regs_next;
    logic [2:0]  flags_reg, flags_next;
    logic [3:0]  op_reg, form_reg;
    logic [2:0]  ridx_reg;
    logic [1:0]  pair_reg, len_reg;
    logic [7:0]  imm_reg, wdata_reg, wdata_next;
    logic [15:0] word_reg, addr_reg, addr_next;
    logic        done_reg, illegal_reg, we_reg, rd_reg;

    // byte and pair access into the flat register vector
    function automatic logic [7:0] get_byte(input logic [63:0] r,
                                            input logic [2:0] i);
        get_byte = r[{i, 3'b000} +: 8];
    endfunction
    function automatic logic [15:0] get_pair(input logic [63:0] r,
                                             input logic [1:0] p);
        get_pair = r[{p, 4'b0000} +: 16];
    endfunction
    function automatic logic [63:0] set_byte(input logic [63:0] r,
                                             input logic [2:0] i,
                                             input logic [7:0] v);
        logic [63:0] t;
        t = r;
        t[{i, 3'b000} +: 8] = v;
        set_byte = t;
    endfunction
    function automatic logic [63:0] set_pair(input logic [63:0] r,
                                             input logic [1:0] p,
                                             input logic [15:0] v);
        logic [63:0] t;
        t = r;
        t[{p, 4'b0000} +: 16] = v;
        set_pair = t;
    endfunction
    function automatic logic is_byte_op(input logic [3:0] op);
        is_byte_op = (op >= OP_ADD) && (op <= OP_XOR);
    endfunction
    function automatic logic is_pair_move(input logic [3:0] op);
        is_pair_move = (op <= OP_WORD_EXCHANGE);
    endfunction
    function automatic logic no_access(input logic [3:0] f);
        no_access = (f == FM_ACC_IMM) || (f == FM_ACC_REG)
                    || (f == FM_REG_ACC);
    endfunction
    // refuse accumulator as partner and unknown forms
    function automatic logic legal(input logic [3:0] op,
                                   input logic [3:0] f,
                                   input logic [2:0] r,
                                   input logic [1:0] p);
        if (is_pair_move(op))
            legal = (p != PAIR_ACC);
        else if (is_byte_op(op))
            legal = (f <= FM_ACC_PTR_C) && !(((f == FM_ACC_REG)
                    || (f == FM_REG_ACC)) && (r == IDX_A));
        else
            legal = 1'b1;
    endfunction
    // clock count per operation and form, fast or slow column
    function automatic logic [4:0] clocks_for(input logic [3:0] op,
                                              input logic [3:0] f,
                                              input logic s);
        if (is_pair_move(op))
            clocks_for = CLK_WORD_MOVE;
        else if (op == OP_WORD_ADD_IMM)
            clocks_for = CLK_WORD_ADD;
        else if (op == OP_UNSIGNED_BYTE_MULTIPLY)
            clocks_for = CLK_MULTIPLY;
        else if (op == OP_UNSIGNED_WORD_DIVIDE)
            clocks_for = CLK_DIVIDE;
        else if (op == OP_PAIR_DECREMENT)
            clocks_for = CLK_PAIR_DEC;
        else if (!is_byte_op(op))
            clocks_for = CLK_ROTATE;
        else if (no_access(f))
            clocks_for = CLK_NO_ACCESS;
        else if (f == FM_SADDR_IMM)
            clocks_for = s ? CLK_SADDR_IMM_SLOW : CLK_SADDR_IMM_FAST;
        else if ((f == FM_ACC_SADDR) || (f == FM_ACC_PTR))
            clocks_for = s ? CLK_SHORT_SLOW : CLK_SHORT_FAST;
        else
            clocks_for = s ? CLK_LONG_SLOW : CLK_LONG_FAST;
    endfunction
    function automatic logic [1:0] len_for(input logic [3:0] op,
                                           input logic [3:0] f);
        if (op == OP_WORD_ADD_IMM)
            len_for = LEN_THREE;
        else if ((op == OP_UNSIGNED_BYTE_MULTIPLY)
                 || (op == OP_UNSIGNED_WORD_DIVIDE))
            len_for = LEN_TWO;
        else if (!is_byte_op(op))
            len_for = LEN_ONE;
        else if ((f == FM_SADDR_IMM) || (f == FM_ACC_ABS))
            len_for = LEN_THREE;
        else if (f == FM_ACC_PTR)
            len_for = LEN_ONE;
        else
            len_for = LEN_TWO;
    endfunction

    // request decode
    logic go, go_ok, commit, idle_load;
    assign go        = START && (state_reg == ST_IDLE);
    assign go_ok     = go && legal(OPCODE, FORM, REG_SEL, PAIR_SEL);
    assign commit    = (state_reg == ST_RUN) && (cnt_reg == 5'h01);
    assign idle_load = (state_reg == ST_IDLE);

    // register views
    logic [7:0]  acc_v, xr_v, c_v, b_v, sel_v;
    logic [15:0] ax_v, hl_v, pair_v;
    assign acc_v  = get_byte(regs_reg, IDX_A);
    assign xr_v   = get_byte(regs_reg, IDX_X);
    assign c_v    = get_byte(regs_reg, IDX_C);
    assign b_v    = get_byte(regs_reg, IDX_B);
    assign sel_v  = get_byte(regs_reg, ridx_reg);
    assign ax_v   = get_pair(regs_reg, PAIR_ACC);
    assign pair_v = get_pair(regs_reg, pair_reg);
    assign hl_v   = {get_byte(regs_reg, IDX_H), get_byte(regs_reg, IDX_L)};

    // data address; pointer forms other than plain HL add the offset at issue
    assign addr_next =
        (FORM == FM_ACC_PTR)     ? hl_v :
        (FORM == FM_ACC_PTR_OFS) ? hl_v + {8'h00, IMM_BYTE} :
        (FORM == FM_ACC_PTR_B)   ? hl_v + {8'h00, b_v} :
        (FORM == FM_ACC_PTR_C)   ? hl_v + {8'h00, c_v} : ADDR_IN;

    // byte alu operands by form
    logic [7:0] alu_d, alu_s, byte_res;
    logic       cin, is_sub;
    logic [8:0] sum9;
    logic [4:0] nib5;
    assign alu_d = (form_reg == FM_SADDR_IMM) ? MEM_RDATA :
                   (form_reg == FM_REG_ACC)   ? sel_v : acc_v;
    assign alu_s = ((form_reg == FM_ACC_IMM) || (form_reg == FM_SADDR_IMM))
                   ? imm_reg :
                   (form_reg == FM_ACC_REG) ? sel_v :
                   (form_reg == FM_REG_ACC) ? acc_v : MEM_RDATA;
    assign cin    = ((op_reg == OP_ADD_WITH_CARRY)
                     || (op_reg == OP_SUBTRACT_WITH_BORROW))
                    && flags_reg[FLAG_CY_BIT];
    assign is_sub = (op_reg == OP_SUBTRACT)
                    || (op_reg == OP_SUBTRACT_WITH_BORROW);
    // nine-bit wrap of the difference yields the borrow in bit 8
    assign sum9 = is_sub ? {1'b0, alu_d} - {1'b0, alu_s} - {8'h00, cin}
                         : {1'b0, alu_d} + {1'b0, alu_s} + {8'h00, cin};
    assign nib5 = is_sub ? {1'b0, alu_d[3:0]} - {1'b0, alu_s[3:0]}
                           - {4'h0, cin}
                         : {1'b0, alu_d[3:0]} + {1'b0, alu_s[3:0]}
                           + {4'h0, cin};
    assign byte_res = (op_reg == OP_AND) ? (alu_d & alu_s) :
                      (op_reg == OP_OR)  ? (alu_d | alu_s) :
                      (op_reg == OP_XOR) ? (alu_d ^ alu_s) :
                      sum9[7:0];

    // word results
    logic [16:0] sum17;
    logic [15:0] quot_v, prod_v;
    logic [7:0]  rem_v;
    logic        add_ac16;
    assign sum17    = {1'b0, ax_v} + {1'b0, word_reg};
    assign add_ac16 = ({1'b0, ax_v[3:0]} + {1'b0, word_reg[3:0]}) > 5'h0F;
    assign prod_v   = {8'h00, acc_v} * {8'h00, xr_v};
    // divide by zero: all-ones quotient, remainder keeps X
    assign quot_v = (c_v == 8'h00) ? DIV_ZERO_QUOT : ax_v / {8'h00, c_v};
    assign rem_v  = (c_v == 8'h00) ? xr_v
                    : 8'(ax_v % {8'h00, c_v});

    // execute at commit, otherwise idle loads
    always_comb
    begin
        regs_next  = regs_reg;
        flags_next = flags_reg;
        wdata_next = wdata_reg;
        if (idle_load && LOAD_EN)
            regs_next = set_byte(regs_next, LOAD_IDX, LOAD_DATA);
        if (idle_load && FLAG_LOAD)
            flags_next = FLAGS_IN;
        if (commit)
        begin
            case (op_reg)
                OP_WORD_MOVE_TO_ACC:
                    regs_next = set_pair(regs_reg, PAIR_ACC, pair_v);
                OP_WORD_MOVE_FROM_ACC:
                    regs_next = set_pair(regs_reg, pair_reg, ax_v);
                OP_WORD_EXCHANGE:
                    regs_next = set_pair(set_pair(regs_reg, PAIR_ACC, pair_v),
                                         pair_reg, ax_v);
                OP_WORD_ADD_IMM:
                begin
                    regs_next  = set_pair(regs_reg, PAIR_ACC, sum17[15:0]);
                    flags_next = {sum17[15:0] == 16'h0000, add_ac16,
                                  sum17[16]};
                end
                OP_UNSIGNED_BYTE_MULTIPLY:
                    regs_next = set_pair(regs_reg, PAIR_ACC, prod_v);
                OP_UNSIGNED_WORD_DIVIDE:
                    regs_next = set_byte(set_pair(regs_reg, PAIR_ACC, quot_v),
                                         IDX_C, rem_v);
                OP_PAIR_DECREMENT:
                    regs_next = set_pair(regs_reg, pair_reg,
                                         pair_v - 16'h0001);
                OP_ROTATE_RIGHT_ONE:
                begin
                    regs_next = set_byte(regs_reg, IDX_A,
                                         {acc_v[0], acc_v[7:1]});
                    flags_next[FLAG_CY_BIT] = acc_v[0];
                end
                OP_ROTATE_LEFT_ONE:
                begin
                    regs_next = set_byte(regs_reg, IDX_A,
                                         {acc_v[6:0], acc_v[7]});
                    flags_next[FLAG_CY_BIT] = acc_v[7];
                end
                default:
                begin
                    // byte group: destination by form
                    if (form_reg == FM_SADDR_IMM)
                        wdata_next = byte_res;
                    else if (form_reg == FM_REG_ACC)
                        regs_next = set_byte(regs_reg, ridx_reg, byte_res);
                    else
                        regs_next = set_byte(regs_reg, IDX_A, byte_res);
                    flags_next[FLAG_Z_BIT] = (byte_res == 8'h00);
                    if (op_reg < OP_AND)
                    begin
                        flags_next[FLAG_AC_BIT] = nib5[4];
                        flags_next[FLAG_CY_BIT] = sum9[8];
                    end
                end
            endcase
        end
    end

    // sequencer: one count per cpu clock edge
    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            ST_IDLE:
                if (go_ok)
                begin
                    state_next = ST_RUN;
                    cnt_next   = clocks_for(OPCODE, FORM, SLOW_AREA)
                                 - 5'h01;
                end
            ST_RUN:
                if (commit)
                    state_next = ST_IDLE;
                else
                    cnt_next = cnt_reg - 5'h01;
            default:
                state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
        begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 5'h00;
            regs_reg  <= REGS_RESET;
            flags_reg <= FLAGS_RESET;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            regs_reg  <= regs_next;
            flags_reg <= flags_next;
        end
    end

    // issue latches and one-cycle status pulses
    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
        begin
            op_reg <= OP_WORD_MOVE_TO_ACC;
            form_reg <= FM_ACC_IMM;
            ridx_reg <= IDX_X;
            pair_reg <= PAIR_ACC;
            imm_reg <= 8'h00;
            word_reg <= 16'h0000;
            addr_reg <= 16'h0000;
            len_reg <= 2'h0;
            rd_reg <= 1'b0;
            wdata_reg <= 8'h00;
            done_reg <= 1'b0;
            illegal_reg <= 1'b0;
            we_reg <= 1'b0;
        end
        else
        begin
            if (go_ok)
            begin
                op_reg <= OPCODE;
                form_reg <= FORM;
                ridx_reg <= REG_SEL;
                pair_reg <= PAIR_SEL;
                imm_reg <= IMM_BYTE;
                word_reg <= IMM_WORD;
                addr_reg <= addr_next;
                len_reg <= len_for(OPCODE, FORM);
                rd_reg <= is_byte_op(OPCODE) && !no_access(FORM);
            end
            wdata_reg <= wdata_next;
            done_reg <= commit;
            illegal_reg <= go && !go_ok;
            we_reg <= commit && is_byte_op(op_reg)
                      && (form_reg == FM_SADDR_IMM);
        end
    end

    assign BUSY      = (state_reg == ST_RUN);
    assign DONE      = done_reg;
    assign ILLEGAL   = illegal_reg;
    assign INSTR_LEN = len_reg;
    assign MEM_ADDR  = addr_reg;
    assign MEM_RE    = BUSY && rd_reg;
    assign MEM_WE    = we_reg;
    assign MEM_WDATA = wdata_reg;
    assign ACC_PAIR  = regs_reg[15:0];
    assign REGS_OUT  = regs_reg;
    assign FLAG_Z    = flags_reg[FLAG_Z_BIT];
    assign FLAG_AC   = flags_reg[FLAG_AC_BIT];
    assign FLAG_CY   = flags_reg[FLAG_CY_BIT];

    // timing and flag checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    sequence s_done4;  (!DONE)[*3] ##1 DONE; endsequence
    sequence s_done6;  (!DONE)[*5] ##1 DONE; endsequence
    sequence s_done8;  (!DONE)[*7] ##1 DONE; endsequence
    sequence s_done9;  (!DONE)[*8] ##1 DONE; endsequence

    a_word_move_time: assert property (go_ok && is_pair_move(OPCODE)
        |=> s_done4) else $error("word move not 4 clocks");
    a_no_access_fast: assert property (go_ok && is_byte_op(OPCODE)
        && FORM == FM_ACC_REG && SLOW_AREA |=> s_done4)
        else $error("no-access form used slow column");
    a_saddr_fast: assert property (go_ok && is_byte_op(OPCODE)
        && FORM == FM_SADDR_IMM && !SLOW_AREA |=> s_done6 ##0 MEM_WE)
        else $error("saddr immediate fast count or write wrong");
    a_saddr_slow: assert property (go_ok && is_byte_op(OPCODE)
        && FORM == FM_SADDR_IMM && SLOW_AREA |=> s_done8)
        else $error("saddr immediate slow count wrong");
    a_ptr_ofs_slow: assert property (go_ok && is_byte_op(OPCODE)
        && FORM == FM_ACC_PTR_OFS && SLOW_AREA |=> s_done9)
        else $error("pointer offset slow count wrong");
    a_ptr_or_slow: assert property (go_ok && OPCODE == OP_OR
        && FORM == FM_ACC_PTR && SLOW_AREA |=> (!DONE)[*4] ##1 DONE)
        else $error("pointer or count wrong");
    a_word_add_time: assert property (go_ok
        && OPCODE == OP_WORD_ADD_IMM |=> s_done6)
        else $error("word add not 6 clocks");
    a_divide_time: assert property (go_ok
        && OPCODE == OP_UNSIGNED_WORD_DIVIDE |-> ##25 DONE)
        else $error("divide not 25 clocks");
    a_multiply_time: assert property (go_ok
        && OPCODE == OP_UNSIGNED_BYTE_MULTIPLY |-> ##16 DONE)
        else $error("multiply not 16 clocks");
    a_illegal_reject: assert property (go && !go_ok
        |=> ILLEGAL && !BUSY) else $error("illegal form accepted");
    a_and_flags: assert property (DONE && op_reg == OP_AND
        |-> FLAG_CY == $past(FLAG_CY) && FLAG_AC == $past(FLAG_AC))
        else $error("and changed carry flags");
    a_decrement_flags: assert property (DONE
        && op_reg == OP_PAIR_DECREMENT |-> $stable(flags_reg))
        else $error("decrement changed flags");
    a_rotate_left: assert property (DONE
        && op_reg == OP_ROTATE_LEFT_ONE
        |-> FLAG_CY == $past(ACC_PAIR[15])
        && ACC_PAIR[8] == $past(ACC_PAIR[15]))
        else $error("rotate left bit 7 misplaced");
    a_rotate_right: assert property (DONE
        && op_reg == OP_ROTATE_RIGHT_ONE
        |-> FLAG_CY == $past(ACC_PAIR[8])
        && ACC_PAIR[15] == $past(ACC_PAIR[8]))
        else $error("rotate right bit 0 misplaced");
endmodule // cad_alu

// ==== hw/cad_pkg.sv ====
// Purpose: shared constants for the cpu alu datapath
// Assumes: one cpu clock, one instruction clock per cycle
// Notes:   opcodes, addressing forms, clock counts, reset values
package cad_pkg;
    // sequencer states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } cad_state_t;

    // operation codes
    localparam logic [3:0] OP_WORD_MOVE_TO_ACC      = 4'h0;
    localparam logic [3:0] OP_WORD_MOVE_FROM_ACC    = 4'h1;
    localparam logic [3:0] OP_WORD_EXCHANGE         = 4'h2;
    localparam logic [3:0] OP_ADD                   = 4'h3;
    localparam logic [3:0] OP_ADD_WITH_CARRY        = 4'h4;
    localparam logic [3:0] OP_SUBTRACT              = 4'h5;
    localparam logic [3:0] OP_SUBTRACT_WITH_BORROW  = 4'h6;
    localparam logic [3:0] OP_AND                   = 4'h7;
    localparam logic [3:0] OP_OR                    = 4'h8;
    localparam logic [3:0] OP_XOR                   = 4'h9;
    localparam logic [3:0] OP_WORD_ADD_IMM          = 4'hA;
    localparam logic [3:0] OP_UNSIGNED_BYTE_MULTIPLY = 4'hB;
    localparam logic [3:0] OP_UNSIGNED_WORD_DIVIDE  = 4'hC;
    localparam logic [3:0] OP_PAIR_DECREMENT        = 4'hD;
    localparam logic [3:0] OP_ROTATE_RIGHT_ONE      = 4'hE;
    localparam logic [3:0] OP_ROTATE_LEFT_ONE       = 4'hF;

    // addressing forms of the byte operations
    localparam logic [3:0] FM_ACC_IMM     = 4'h0;
    localparam logic [3:0] FM_SADDR_IMM   = 4'h1;
    localparam logic [3:0] FM_ACC_REG     = 4'h2;
    localparam logic [3:0] FM_REG_ACC     = 4'h3;
    localparam logic [3:0] FM_ACC_SADDR   = 4'h4;
    localparam logic [3:0] FM_ACC_ABS     = 4'h5;
    localparam logic [3:0] FM_ACC_PTR     = 4'h6;
    localparam logic [3:0] FM_ACC_PTR_OFS = 4'h7;
    localparam logic [3:0] FM_ACC_PTR_B   = 4'h8;
    localparam logic [3:0] FM_ACC_PTR_C   = 4'h9;

    // general register indices and pair codes
    localparam logic [2:0] IDX_X = 3'h0;
    localparam logic [2:0] IDX_A = 3'h1;
    localparam logic [2:0] IDX_C = 3'h2;
    localparam logic [2:0] IDX_B = 3'h3;
    localparam logic [2:0] IDX_L = 3'h6;
    localparam logic [2:0] IDX_H = 3'h7;
    localparam logic [1:0] PAIR_ACC = 2'h0;

    // instruction clock counts
    localparam logic [4:0] CLK_NO_ACCESS      = 5'h04;
    localparam logic [4:0] CLK_SADDR_IMM_FAST = 5'h06;
    localparam logic [4:0] CLK_SADDR_IMM_SLOW = 5'h08;
    localparam logic [4:0] CLK_SHORT_FAST     = 5'h04;
    localparam logic [4:0] CLK_SHORT_SLOW     = 5'h05;
    localparam logic [4:0] CLK_LONG_FAST      = 5'h08;
    localparam logic [4:0] CLK_LONG_SLOW      = 5'h09;
    localparam logic [4:0] CLK_WORD_MOVE      = 5'h04;
    localparam logic [4:0] CLK_WORD_ADD       = 5'h06;
    localparam logic [4:0] CLK_MULTIPLY       = 5'h10;
    localparam logic [4:0] CLK_DIVIDE         = 5'h19;
    localparam logic [4:0] CLK_PAIR_DEC       = 5'h04;
    localparam logic [4:0] CLK_ROTATE         = 5'h02;

    // instruction lengths in bytes
    localparam logic [1:0] LEN_ONE   = 2'h1;
    localparam logic [1:0] LEN_TWO   = 2'h2;
    localparam logic [1:0] LEN_THREE = 2'h3;

    // reset values and special results
    localparam logic [63:0] REGS_RESET    = 64'h0;
    localparam logic [2:0]  FLAGS_RESET   = 3'h0;
    localparam logic [15:0] DIV_ZERO_QUOT = 16'hFFFF;

    // bit positions in the flag load word
    localparam int FLAG_Z_BIT  = 2;
    localparam int FLAG_AC_BIT = 1;
    localparam int FLAG_CY_BIT = 0;
endpackage

// ==== verification/cad_alu_bench.sv ====
// Purpose: self-checking bench for the alu datapath
// Assumes: inputs move on the falling clock edge
// Notes:   n counts cycles from accept edge to the answer
`timescale 1ns/10ps
module cpu_alu_datapath_bench;
    import cad_pkg::*;
    logic        clk = 0, rstn, start, slow, lden, fld, busy, done, ill;
    logic        mwe, fz, fac, fcy, mre, rd;
    logic [3:0]  op, fm;
    logic [2:0]  rsel, ldidx, fin;
    logic [1:0]  psel, len;
    logic [7:0]  imm = 0, rdata = 0, lddat = 0, mwd;
    logic [15:0] immw = 0, addr = 0, maddr, acc;
    logic [63:0] regs;
    int          failures = 0, samples_checked = 0, n;
    cad_alu uut (.CLK_SYS(clk), .RSTN(rstn), .START(start), .OPCODE(op),
        .FORM(fm), .REG_SEL(rsel), .PAIR_SEL(psel), .IMM_BYTE(imm),
        .IMM_WORD(immw), .ADDR_IN(addr), .SLOW_AREA(slow),
        .MEM_RDATA(rdata), .LOAD_EN(lden), .LOAD_IDX(ldidx),
        .LOAD_DATA(lddat), .FLAG_LOAD(fld), .FLAGS_IN(fin), .BUSY(busy),
        .DONE(done), .ILLEGAL(ill), .INSTR_LEN(len), .MEM_ADDR(maddr),
        .MEM_RE(mre), .MEM_WE(mwe), .MEM_WDATA(mwd), .ACC_PAIR(acc),
        .REGS_OUT(regs), .FLAG_Z(fz), .FLAG_AC(fac), .FLAG_CY(fcy));
    // 25 MHz cpu clock
    initial forever #20 clk = ~clk;
    task chk(input string what, input logic [15:0] e, g);
        samples_checked++;
        failures += int'(g !== e);
        if (g !== e)
            $display("Error %s expected %h seen %h", what, e, g);
    endtask
    task ld(input logic [2:0] i, input logic [7:0] d, input logic f);
        {lden, fld, ldidx, lddat, fin} = {!f, f, i, d, d[2:0]};
        @(negedge clk);
        {lden, fld} = 2'h0;
        // one idle edge so a following load never re-raises in one step
        @(negedge clk);
    endtask
    task go(input logic [3:0] o, f, input logic [7:0] b);
        {op, fm, imm, start, rd} = {o, f, b, 1'b1, 1'b0};
        @(negedge clk);
        start = 0;
        for (n = 1; (done | ill) !== 1'b1 && n < 40; n++)
        begin
            rd |= mre;
            @(negedge clk);
        end
    endtask
    task t_rotate;
        ld(IDX_A, 8'h81, 0);
        go(OP_ROTATE_LEFT_ONE, FM_ACC_IMM, 8'h00);
        chk("rol n a cy", 16'h2031, {n[3:0], acc[15:8], 3'h0, fcy});
    endtask
    task t_carry;
        ld(3'h0, 8'h01, 1);
        ld(IDX_A, 8'h81, 0);
        go(OP_ADD_WITH_CARRY, FM_ACC_IMM, 8'h7E);
        chk("add_with_carry", 16'h4007, {n[3:0], acc[15:8], 1'h0, fz, fac, fcy});
        {addr, slow, rdata} = {16'hFE20, 1'b1, 8'h10};
        go(OP_SUBTRACT_WITH_BORROW, FM_SADDR_IMM, 8'h20);
        chk("subtract_with_borrow", 16'h87EF, {n[3:0], 1'h0, len, mwe, mwd});
        chk("subtract_with_borrow flags", 16'h3, {13'h0, fz, fac, fcy});
    endtask
    task t_wide;
        ld(IDX_X, 8'h64, 0);
        ld(IDX_C, 8'h07, 0);
        go(OP_UNSIGNED_WORD_DIVIDE, FM_ACC_IMM, 8'h00);
        chk("divu n rem", 16'h1902, {n[7:0], regs[23:16]});
        chk("divu quot", 16'h000E, acc);
        immw = 16'h0001;
        go(OP_WORD_ADD_IMM, FM_ACC_IMM, 8'h00);
        chk("addw n cy", 16'h0600, {n[7:0], 7'h0, fcy});
        chk("addw sum", 16'h000F, acc);
        go(OP_WORD_EXCHANGE, FM_ACC_IMM, 8'h00);
        chk("refused", 16'h0102, {n[7:0], 6'h0, ill, busy});
    endtask
    // register and pointer forms, multiply, decrement, moves, refusal
    task t_bytes;
        {slow, rsel, rdata} = {1'b1, IDX_B, 8'h10};
        ld(IDX_A, 8'h50, 0);
        ld(IDX_B, 8'hAF, 0);
        ld(IDX_H, 8'h12, 0);
        ld(IDX_L, 8'h34, 0);
        go(OP_XOR, FM_REG_ACC, 8'h00);
        chk("xor", 16'h40FF, {n[3:0], 3'h0, rd, regs[31:24]});
        go(OP_SUBTRACT, FM_ACC_REG, 8'h00);
        chk("sub", 16'h4513, {n[3:0], acc[15:8], 1'h0, fz, fac, fcy});
        go(OP_AND, FM_ACC_IMM, 8'h0E);
        chk("and", 16'h4007, {n[3:0], acc[15:8], 1'h0, fz, fac, fcy});
        go(OP_OR, FM_ACC_PTR, 8'h00);
        chk("or", 16'h5610, {n[3:0], len, rd, 1'h0, acc[15:8]});
        chk("or addr", 16'h1234, maddr);
        go(OP_ADD, FM_ACC_PTR_OFS, 8'h02);
        chk("add ofs", 16'h9020, {n[3:0], 4'h0, acc[15:8]});
        chk("ofs addr", 16'h1236, maddr);
        ld(3'h0, 8'h07, 1);
        go(OP_UNSIGNED_BYTE_MULTIPLY, FM_ACC_IMM, 8'h00);
        chk("unsigned_byte_multiply", 16'h01E0, acc);
        chk("unsigned_byte_multiply n flags", 16'h1007, {n[7:0], 5'h0, fz, fac, fcy});
        psel = 2'h3;
        go(OP_PAIR_DECREMENT, FM_ACC_IMM, 8'h00);
        chk("pair_decrement hl", 16'h1233, regs[63:48]);
        chk("pair_decrement n flags", 16'h0407, {n[7:0], 5'h0, fz, fac, fcy});
        ld(3'h0, 8'h00, 1);
        go(OP_ROTATE_RIGHT_ONE, FM_ACC_IMM, 8'h00);
        chk("ror n a cy", 16'h2801, {n[3:0], acc[15:8], 3'h0, fcy});
        go(OP_WORD_MOVE_TO_ACC, FM_ACC_IMM, 8'h00);
        chk("word_move ax", 16'h1233, acc);
        chk("word_move n", 16'h0004, n[15:0]);
        {slow, rsel} = {1'b0, IDX_A};
        go(OP_ADD, FM_SADDR_IMM, 8'h01);
        chk("add saddr", 16'h6111, {n[3:0], 3'h0, mwe, mwd});
        go(OP_ADD, FM_ACC_REG, 8'h00);
        chk("no a,a", 16'h1212, {n[3:0], 2'h0, ill, busy, acc[15:8]});
    endtask
    task print_verdict;
        $display("failures %0d checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // reset for 5 cycles, then the scenarios in turn
    initial
    begin
        {rstn, start, slow, lden, fld, op, fm, rsel, ldidx, fin, psel} = 0;
        repeat (5) @(negedge clk);
        rstn = 1;
        t_rotate;
        t_carry;
        t_wide;
        t_bytes;
        print_verdict;
    end
    // watchdog: the tests need about 130 cycles
    initial
    begin
        repeat (2000) @(posedge clk);
        failures++;
        print_verdict;
    end
endmodule // cpu_alu_datapath_bench
